// *** rtl/pss_core.sv ***
// Program sequencer core: four-phase cycle, prefetch, return stack,
// accumulator ALU and an APB register slave.
// Assumes program memory and data memory read combinationally, and
// interrupt logic holds irq_req until it sees irq_ack.
//
// Overview of operation
// - Four phases make one instruction cycle
// - Fetch phase advances counter, fetches word
// - Later phases decode and execute instruction
// - Fetch overlaps execute; branches take two
// - Counter increments unless control is transferred
// - Only counter low byte is software visible
// - Jump, call, interrupt, reset load target
// - Taken skip discards prefetch, runs dummy cycle
// - Low-byte write jumps in page, dummy cycle
// - Return stack hidden from software
// - Call or interrupt acknowledge pushes counter
// - Return instructions pop into counter
// - Reset empties the return stack
// - Full stack withholds acknowledge until return
// - Call on full stack drops oldest
// - Stack depth is four, eight or twelve
// - ALU updates status flags and destination
// - ALU arithmetic, logic, rotate, increment, decrement
// - Execution starts at address zero
`timescale 1ns/1ps
`default_nettype none
module pss_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [pss_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [pss_pkg::PC_W-1:0] pm_addr,
  input wire logic [pss_pkg::IW-1:0] pm_rdata,
  output var pss_pkg::pss_dm_t dm,
  input wire logic [7:0] dm_rdata,
  input wire logic irq_req,
  output logic irq_ack
);
  import pss_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // State
  pss_phase_t ph_q;
  logic run_q;
  logic [PC_W-1:0] pc_q;
  logic [PC_W-1:0] pfa_q;
  logic [IW-1:0] pf_q;
  pss_instr_t ir_q;
  logic flush_q;
  logic [7:0] opnd_q;
  logic [7:0] acc_q;
  pss_flags_t flg_q;
  logic [PC_W-1:0] stk_q [STK_DEPTH];
  logic [SP_W-1:0] cnt_q;
  pss_dm_t dm_q;
  logic ack_q;
  logic pcl_pend_q;
  logic [7:0] pcl_val_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic live_q;

  ////////////////////////////////////////////////////////////////////
  // Accumulator ALU; carry set after subtract means no borrow
  function automatic pss_alu_t alu_op(input pss_func_t fn,
                                      input logic [7:0] a,
                                      input logic [7:0] m,
                                      input pss_flags_t fi);
    logic sub;
    logic cin;
    logic [7:0] b;
    logic [8:0] s;
    logic [4:0] h;
    begin
      alu_op.f = fi;
      alu_op.r = 8'h00;
      sub = (fn == F_SUB) || (fn == F_SBC);
      b = sub ? ~m : m;
      cin = (fn == F_ADC || fn == F_SBC) ? fi.c : sub;
      s = {1'h0, a} + {1'h0, b} + {8'h00, cin};
      h = {1'h0, a[3:0]} + {1'h0, b[3:0]} + {4'h0, cin};
      unique case (fn)
        F_ADD, F_ADC, F_SUB, F_SBC:
        begin
          alu_op.r = s[7:0];
          alu_op.f.c = s[8];
          alu_op.f.ac = h[4];
          alu_op.f.ov = (a[7] == b[7]) && (s[7] != a[7]);
        end
        F_AND: alu_op.r = a & m;
        F_OR: alu_op.r = a | m;
        F_XOR: alu_op.r = a ^ m;
        F_CPL: alu_op.r = ~m;
        F_RR: alu_op.r = {m[0], m[7:1]};
        F_RRC:
        begin
          alu_op.r = {fi.c, m[7:1]};
          alu_op.f.c = m[0];
        end
        F_RL: alu_op.r = {m[6:0], m[7]};
        F_RLC:
        begin
          alu_op.r = {m[6:0], fi.c};
          alu_op.f.c = m[7];
        end
        F_INC: alu_op.r = m + 8'h01;
        F_DEC: alu_op.r = m - 8'h01;
        F_DAA:
        begin
          // Low nibble fix first, then high nibble from its result
          b = (a[3:0] > 4'h9 || fi.ac) ? 8'h06 : 8'h00;
          s = {1'h0, a} + {1'h0, b};
          alu_op.f.c = fi.c || s[8] || (s[7:4] > 4'h9);
          alu_op.r = s[7:0] + (alu_op.f.c ? 8'h60 : 8'h00);
        end
        F_MOV: alu_op.r = m;
      endcase
      // Rotates and moves leave the zero flag alone
      if (!(fn inside {F_RR, F_RRC, F_RL, F_RLC, F_MOV}))
        alu_op.f.z = (alu_op.r == 8'h00);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Decode of the executing word, valid through the later phases
  wire logic fe = run_q && (ph_q == PH_FETCH);
  wire logic ex = run_q && (ph_q == PH_EX3);
  wire pss_ctl_t ck = pss_ctl_t'(ir_q.func[3:2]);
  wire pss_skip_t sk = pss_skip_t'(ir_q.func[3:2]);
  wire logic is_alu = (ir_q.cls == CL_ALU);
  wire logic is_br = (ir_q.cls == CL_BR);
  wire logic is_call = is_br && ir_q.func[3];
  wire logic is_ret = (ir_q.cls == CL_CTL) && (ck == K_RET || ck == K_INTERRUPT_RETURN);
  wire logic is_sta = (ir_q.cls == CL_CTL) && (ck == K_STA);
  wire logic is_skip = (ir_q.cls == CL_SKIP);
  wire logic [PC_W-1:0] jt = ir_q[PC_W-1:0];
  wire logic [PC_W-1:0] top = stk_q[0];
  wire logic [PC_W-9:0] pc_hi = pc_q[PC_W-1:8];

  // Skip tests; increment and decrement forms write back first
  wire logic [7:0] sv = (sk == S_SIZ) ? opnd_q + 8'h01 : opnd_q - 8'h01;
  wire logic skip_hit = is_skip && ((sk == S_SZ) ? opnd_q == 8'h00 :
                                    (sk == S_SNZ) ? opnd_q != 8'h00 :
                                    sv == 8'h00);
  wire logic skip_wr = is_skip && (sk == S_SIZ || sk == S_SDZ);

  // Redirects; a pending low-byte write waits behind a branch
  wire logic full = (cnt_q == STK_FULL);
  wire logic redir = is_br || is_ret || skip_hit;
  wire logic pcl_go = ex && pcl_pend_q && !redir;
  wire logic irq_go = ex && irq_req && !full && !redir && !pcl_pend_q;
  wire logic push = (ex && is_call) || irq_go;
  wire logic pop = ex && is_ret;
  wire logic flush_d = (ex && redir) || irq_go || pcl_go;
  wire logic tgt_ld = irq_go || pcl_go || (ex && (is_br || is_ret));
  wire logic [PC_W-1:0] tgt = irq_go ? IRQ_VEC :
                              is_ret ? top :
                              is_br ? jt : {pc_hi, pcl_val_q};

  // Result routing to accumulator or data memory
  wire pss_alu_t ar = alu_op(pss_func_t'(ir_q.func), acc_q, opnd_q, flg_q);
  wire logic [7:0] res = is_alu ? ar.r : is_skip ? sv : acc_q;
  wire logic wr_acc = ex && (is_alu || skip_wr) && !ir_q.dst;
  wire logic wr_mem = ex && (((is_alu || skip_wr) && ir_q.dst) || is_sta);

  ////////////////////////////////////////////////////////////////////
  // APB decode; stack has no address so it stays hidden
  wire logic setup = psel && !penable;
  wire logic wr = psel && penable && pwrite && pready_q;
  wire logic a_pcl = (paddr == OFS_PCL);
  wire logic a_st = (paddr == OFS_STAT);
  wire logic a_ct = (paddr == OFS_CTRL);
  wire logic bad = !(a_pcl || a_ct || (a_st && !pwrite));
  wire logic [31:0] rd = a_pcl ? {24'h000000, pc_q[7:0]} :
                         a_st ? {14'h0000, ph_q, cnt_q, flg_q, acc_q} :
                         a_ct ? {31'h00000000, run_q} : 32'h00000000;

  ////////////////////////////////////////////////////////////////////
  // Phase counter; clearing run freezes the cycle where it stands
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      ph_q <= PH_FETCH;
      run_q <= CTRL_RUN_RST;
    end
    else
    begin
      if (run_q)
        ph_q <= pss_phase_t'(ph_q + 2'h1);
      if (wr && a_ct)
        run_q <= pwdata[CTRL_RUN];
    end

  // Fetch in the first phase while the previous word executes
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      pc_q <= RESET_VEC;
      pfa_q <= RESET_VEC;
      pf_q <= NOP_WORD;
      ir_q <= NOP_WORD;
      flush_q <= 1'h0;
    end
    else if (fe)
    begin
      ir_q <= flush_q ? NOP_WORD : pf_q;
      pf_q <= pm_rdata;
      pfa_q <= pc_q;
      pc_q <= pc_q + 1'h1;
      flush_q <= 1'h0;
    end
    else if (ex)
    begin
      if (tgt_ld)
        pc_q <= tgt;
      flush_q <= flush_d;
    end

  // Operand address in phase two, operand latched in phase three, results written in phase four
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      opnd_q <= 8'h00;
      acc_q <= 8'h00;
      flg_q <= '0;
      dm_q <= '0;
      ack_q <= 1'h0;
    end
    else
    begin
      dm_q.we <= wr_mem;
      ack_q <= irq_go;
      if (run_q && ph_q == PH_EX1)
        dm_q.addr <= ir_q.addr;
      if (run_q && ph_q == PH_EX2)
        opnd_q <= dm_rdata;
      if (wr_mem)
        dm_q.wdata <= res;
      if (wr_acc)
        acc_q <= res;
      if (ex && is_alu)
        flg_q <= ar.f;
    end

  ////////////////////////////////////////////////////////////////////
  // Shift-register stack; a push when full drops the bottom entry
  for (genvar i = 0; i < STK_DEPTH; i++)
  begin : g_stk
    wire logic [PC_W-1:0] up = (i == 0) ? pfa_q :
                                 stk_q[(i + STK_DEPTH - 1) % STK_DEPTH];
    wire logic [PC_W-1:0] dn = (i == STK_DEPTH - 1) ? RESET_VEC :
                                 stk_q[(i + 1) % STK_DEPTH];
    always_ff @(posedge pclk or negedge presetn)
      if (!presetn)
        stk_q[i] <= RESET_VEC;
      else if (push)
        stk_q[i] <= up;
      else if (pop)
        stk_q[i] <= dn;
  end

  // Fill level; saturates because overflow discards, not wraps
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      cnt_q <= '0;
    else if (push && !full)
      cnt_q <= cnt_q + 1'h1;
    else if (pop && cnt_q != '0)
      cnt_q <= cnt_q - 1'h1;

  ////////////////////////////////////////////////////////////////////
  // APB answers one cycle after setup, no wait states
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      prdata_q <= 32'h00000000;
      pready_q <= 1'h0;
      pslverr_q <= 1'h0;
      pcl_pend_q <= 1'h0;
      pcl_val_q <= 8'h00;
    end
    else
    begin
      pready_q <= setup;
      if (setup)
      begin
        prdata_q <= rd;
        pslverr_q <= bad;
      end
      // New write wins over a jump consuming the old one
      if (wr && a_pcl)
      begin
        pcl_pend_q <= 1'h1;
        pcl_val_q <= pwdata[7:0];
      end
      else if (pcl_go)
        pcl_pend_q <= 1'h0;
    end

  // Checks wait one clock past reset, since the release edge still resets
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      live_q <= 1'h0;
    else
      live_q <= 1'h1;

  // Every output straight from a flip-flop
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign pm_addr = pc_q;
  assign dm = dm_q;
  assign irq_ack = ack_q;

  ////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn || !live_q);

  chk_phase_cycle: assert property (fe ##1 run_q [*3] |=> ph_q == PH_FETCH)
    else $error("phases did not wrap in four clocks");
  chk_fetch_step: assert property (fe |=> pm_addr == $past(pm_addr) + 1'h1)
    else $error("fetch did not advance the counter");
  chk_seq_hold: assert property (ex && !tgt_ld |=> pm_addr == $past(pm_addr))
    else $error("counter moved without a transfer");
  chk_flush_nop: assert property (fe && flush_q |=> ir_q == NOP_WORD)
    else $error("flushed word was executed");
  chk_skip_dummy: assert property (ex && skip_hit |=> ##1 ir_q == NOP_WORD)
    else $error("taken skip gave no dummy cycle");
  chk_jump_load: assert property (ex && is_br |=> pm_addr == $past(jt))
    else $error("branch target not loaded");
  chk_pcl_page: assert property (pcl_go |=> pc_hi == $past(pc_hi)
                                 && pm_addr[7:0] == $past(pcl_val_q))
    else $error("low byte jump left the page");
  chk_call_push: assert property (ex && is_call |=> top == $past(pfa_q))
    else $error("call did not push return address");
  chk_ret_pop: assert property (ex && is_ret |=> pm_addr == $past(top))
    else $error("return did not reload the counter");
  chk_full_block: assert property (ex && irq_req && full |=> !irq_ack)
    else $error("acknowledge given with full stack");
  chk_overflow_keep: assert property (push && full |=> cnt_q == STK_FULL)
    else $error("overflow changed the fill level");
  chk_push_level: assert property (push && !full |=> cnt_q == $past(cnt_q) + 1'h1)
    else $error("push did not raise the fill level");
  chk_pop_level: assert property (pop && cnt_q != '0 |=> cnt_q == $past(cnt_q) - 1'h1)
    else $error("pop did not lower the fill level");
  chk_irq_vector: assert property (irq_go |=> pm_addr == IRQ_VEC)
    else $error("interrupt entry not loaded");
  chk_fetch_word: assert property (fe && !flush_q |=> ir_q == $past(pf_q))
    else $error("prefetched word not handed on");
  chk_ack_pulse: assert property (irq_go |=> irq_ack ##1 !irq_ack)
    else $error("acknowledge not a single pulse");
  chk_redir_flush: assert property (ex && redir |=> flush_q)
    else $error("redirect did not mark a dummy cycle");

  cov_call: cover property (ex && is_call ##4 ex && is_ret);
  cov_irq_ack: cover property (irq_ack);
  cov_skip: cover property (ex && skip_hit);
  cov_pcl_jump: cover property (pcl_go);
  cov_stack_full: cover property (ex && irq_req && full);
endmodule
`default_nettype wire

// *** rtl/pss_pkg.sv ***
// Shared constants and types for the program sequencer core.
// Assumes one pclk domain and an APB register slave in the core.
`default_nettype none
package pss_pkg;
  // Program counter and instruction word widths
  localparam int PC_W = 11;
  localparam int IW = 16;
  // Return stack depth: 4, 8 or 12 per device variant
  localparam int STK_DEPTH = 8;
  localparam int SP_W = 4;
  localparam logic [SP_W-1:0] STK_FULL = SP_W'(STK_DEPTH);
  // Reset vector, interrupt entry and the no-operation word
  localparam logic [PC_W-1:0] RESET_VEC = 11'h000;
  localparam logic [PC_W-1:0] IRQ_VEC = 11'h004;
  localparam logic [IW-1:0] NOP_WORD = 16'h8000;
  // APB register map
  localparam int APB_AW = 8;
  localparam logic [APB_AW-1:0] OFS_PCL = 8'h00;
  localparam logic [APB_AW-1:0] OFS_STAT = 8'h04;
  localparam logic [APB_AW-1:0] OFS_CTRL = 8'h08;
  localparam int CTRL_RUN = 0;
  localparam logic CTRL_RUN_RST = 1'h1;

  typedef enum logic [1:0] {
    PH_FETCH = 2'b00, PH_EX1 = 2'b01, PH_EX2 = 2'b10, PH_EX3 = 2'b11
  } pss_phase_t;
  typedef enum logic [1:0] {
    CL_ALU = 2'b00, CL_BR = 2'b01, CL_CTL = 2'b10, CL_SKIP = 2'b11
  } pss_class_t;
  typedef enum logic [3:0] {
    F_ADD = 4'b0000, F_ADC = 4'b0001, F_SUB = 4'b0010, F_SBC = 4'b0011,
    F_AND = 4'b0100, F_OR = 4'b0101, F_XOR = 4'b0110, F_CPL = 4'b0111,
    F_RR = 4'b1000, F_RRC = 4'b1001, F_RL = 4'b1010, F_RLC = 4'b1011,
    F_INC = 4'b1100, F_DEC = 4'b1101, F_DAA = 4'b1110, F_MOV = 4'b1111
  } pss_func_t;
  typedef enum logic [1:0] {
    K_NOP = 2'b00, K_RET = 2'b01, K_INTERRUPT_RETURN = 2'b10, K_STA = 2'b11
  } pss_ctl_t;
  typedef enum logic [1:0] {
    S_SZ = 2'b00, S_SNZ = 2'b01, S_SIZ = 2'b10, S_SDZ = 2'b11
  } pss_skip_t;

  // Instruction word; branches use the low PC_W bits as target
  typedef struct packed {
    pss_class_t cls;
    logic [3:0] func;
    logic dst;
    logic spare;
    logic [7:0] addr;
  } pss_instr_t;
  typedef struct packed {
    logic ov;
    logic z;
    logic ac;
    logic c;
  } pss_flags_t;
  typedef struct packed {
    pss_flags_t f;
    logic [7:0] r;
  } pss_alu_t;
  // Data memory port
  typedef struct packed {
    logic we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pss_dm_t;
endpackage
`default_nettype wire

// *** dv/pss_mem_model.sv ***
// Far-side model: program memory, data memory and interrupt source.
// Assumes the core reads both memories combinationally at its own edges.
`timescale 1ns/1ps
`default_nettype none
module pss_mem_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [pss_pkg::PC_W-1:0] pm_addr,
  output logic [pss_pkg::IW-1:0] pm_rdata,
  input wire pss_pkg::pss_dm_t dm,
  output logic [7:0] dm_rdata,
  input wire logic irq_fire,
  output logic irq_req,
  input wire logic irq_ack
);
  import pss_pkg::*;
  logic [IW-1:0] rom [0:(2**PC_W)-1];
  logic [7:0] ram [0:255];
  //////////////////////////////////////////////////////////////////////
  // Program image: main line, subroutine, skip, handler, page-1 loops
  initial
  begin
    for (int i = 0; i < 2**PC_W; i++) rom[i] = NOP_WORD;
    for (int i = 0; i < 256; i++) ram[i] = 8'h00;
    ram[8'h10] = 8'h05;
    ram[8'h11] = 8'h03;
    ram[8'h32] = 8'hEE;
    rom[11'h000] = 16'h3C10; // Load accumulator from 0x10
    rom[11'h001] = 16'h6020; // Call 0x020
    rom[11'h002] = 16'hB031; // Store after return
    rom[11'h003] = 16'h4103; // Jump into page 1
    rom[11'h004] = 16'hB033; // Handler store
    rom[11'h005] = 16'hA000; // Interrupt return
    rom[11'h020] = 16'h0011; // Add 0x11
    rom[11'h021] = 16'hB030;
    rom[11'h022] = 16'hC012; // Skip if 0x12 is zero
    rom[11'h023] = 16'hB032; // Must never execute
    rom[11'h024] = 16'h9000; // Return
    rom[11'h103] = 16'h4103; // Idle loop
    rom[11'h106] = 16'hB034; // Reached by low-byte write
    rom[11'h107] = 16'h4107;
    rom[11'h10A] = 16'h610A; // Calls itself endlessly, on past the point where the stack is full
    rom[11'h10B] = 16'h410B; // Parking loop after the handler returns
    rom[11'h10C] = 16'h9000; // Return reached by low-byte write
  end
  // Memories answer at once; no wait states on this side
  assign pm_rdata = rom[pm_addr];
  assign dm_rdata = ram[dm.addr];
  always @(posedge pclk)
  begin
    if (dm.we === 1'b1) ram[dm.addr] <= dm.wdata;
  end
  // Request level holds until acknowledged, as interrupt logic does
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn) irq_req <= 1'b0;
    else if (irq_ack) irq_req <= 1'b0;
    else if (irq_fire) irq_req <= 1'b1;
  end
endmodule
`default_nettype wire

// *** dv/test_pss_core.sv ***
// Testbench for the program sequencer core over APB and memory model.
// Assumes pss_pkg constants and a zero-wait APB slave in the core.
`timescale 1ns/1ps
`default_nettype none
module test_pss_core;
  import pss_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, irq_fire = 1'b0;
  logic [APB_AW-1:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, err, irq_req, irq_ack;
  logic [PC_W-1:0] pm_addr;
  logic [IW-1:0] pm_rdata;
  logic [7:0] dm_rdata;
  pss_dm_t dm;
  int failures = 0, cmp_count = 0, cyc = 0, n;
  int wr_cyc [0:255];
  //////////////////////////////////////////////////////////////////////
  pss_core i_pss_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pm_addr(pm_addr), .pm_rdata(pm_rdata), .dm(dm),
    .dm_rdata(dm_rdata), .irq_req(irq_req), .irq_ack(irq_ack));
  pss_mem_model i_pss_mem_model (.pclk(pclk), .presetn(presetn), .pm_addr(pm_addr),
    .pm_rdata(pm_rdata), .dm(dm), .dm_rdata(dm_rdata), .irq_fire(irq_fire),
    .irq_req(irq_req), .irq_ack(irq_ack));
  always #2.5 pclk = ~pclk;
  // Clock stamp of each data write, for cycle spacing checks
  always @(posedge pclk)
  begin
    cyc <= cyc + 1;
    if (dm.we === 1'b1) wr_cyc[dm.addr] <= cyc;
  end
  //////////////////////////////////////////////////////////////////////
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // One APB transfer; waits for pready without assuming latency
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    if (k >= 50) chk("pready", 0, 1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////
  // Main sequence
  initial
  begin
    repeat (16) @(posedge pclk);
    chk("reset pc", pm_addr, 0);
    presetn <= 1'b1;
    apb(1'b0, OFS_STAT, 0);
    chk("empty stack", rd[15:12], 0);
    apb(1'b0, OFS_CTRL, 0);
    chk("ctrl reset", rd[0], CTRL_RUN_RST);
    apb(1'b1, OFS_STAT, 32'h0000_00FF);
    chk("stat write refused", err, 1);
    apb(1'b0, 8'h0C, 0);
    chk("unmapped", err, 1);
    repeat (100) @(posedge pclk);
    // Call, add, skip and return program has run by now
    chk("sum in sub", i_pss_mem_model.ram[8'h30], 8'h08);
    chk("after return", i_pss_mem_model.ram[8'h31], 8'h08);
    chk("skipped store", i_pss_mem_model.ram[8'h32], 8'hEE);
    chk("gap clocks", wr_cyc[8'h31] - wr_cyc[8'h30], 20);
    apb(1'b0, OFS_STAT, 0);
    chk("acc", rd[7:0], 8'h08);
    chk("flags", rd[11:8], 4'h0);
    chk("stack popped", rd[15:12], 0);
    // Interrupt while idling in page 1
    @(posedge pclk);
    irq_fire <= 1'b1;
    @(posedge pclk);
    irq_fire <= 1'b0;
    n = 0;
    while (irq_ack !== 1'b1 && n < 200)
    begin
      @(posedge pclk);
      n++;
    end
    chk("irq ack", irq_ack, 1);
    repeat (60) @(posedge pclk);
    chk("handler ran", i_pss_mem_model.ram[8'h33], 8'h08);
    apb(1'b0, OFS_STAT, 0);
    chk("interrupt_return popped", rd[15:12], 0);
    // Low-byte write jumps within page 1
    apb(1'b1, OFS_PCL, 32'h0000_0006);
    chk("pcl write ok", err, 0);
    repeat (60) @(posedge pclk);
    chk("page jump", i_pss_mem_model.ram[8'h34], 8'h08);
    chk("upper kept", pm_addr[10:8], 3'h1);
    apb(1'b0, OFS_PCL, 0);
    chk("pcl read", (rd[7:0] == 8'h07) || (rd[7:0] == 8'h08), 1);
    apb(1'b1, OFS_CTRL, 0);
    apb(1'b0, OFS_CTRL, 0);
    chk("ctrl rw", rd[0], 0);
    apb(1'b1, OFS_CTRL, 1);
    // Endless self-call fills the stack; a pending interrupt must wait
    apb(1'b1, OFS_PCL, 32'h0000_000A);
    repeat (120) @(posedge pclk);
    irq_fire <= 1'b1;
    @(posedge pclk);
    irq_fire <= 1'b0;
    n = 0;
    repeat (40)
    begin
      @(posedge pclk);
      if (irq_ack === 1'b1) n++;
    end
    chk("full no ack", n, 0);
    apb(1'b0, OFS_STAT, 0);
    chk("full level", rd[15:12], STK_DEPTH);
    // Low-byte jump to a return frees a level and lets the request in
    apb(1'b1, OFS_PCL, 32'h0000_000C);
    n = 0;
    while (irq_ack !== 1'b1 && n < 200)
    begin
      @(posedge pclk);
      n++;
    end
    chk("ack after return", irq_ack, 1);
    repeat (40) @(posedge pclk);
    apb(1'b0, OFS_STAT, 0);
    chk("level after interrupt_return", rd[15:12], STK_DEPTH - 1);
    // Reset in mid-run empties the stack and restarts at zero
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    chk("reset pc again", pm_addr, 0);
    presetn <= 1'b1;
    apb(1'b0, OFS_STAT, 0);
    chk("stack emptied", rd[15:12], 0);
    repeat (8) @(posedge pclk);
    close_out();
  end
  // Watchdog well beyond the expected run length
  initial
  begin
    repeat (20000) @(posedge pclk);
    failures++;
    close_out();
  end
endmodule
`default_nettype wire
